// ### design/redriver_pkg.sv
// shared constants and types for the redriver control logic
package redriver_pkg;
  localparam int CLK_NS          = 4;
  localparam int STRAP_HOLD_NS   = 10000;
  localparam int STRAP_HOLD_CYC  = (STRAP_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RXDET_INTVL_MS  = 12;
  localparam int RXDET_INTVL_CYC = (RXDET_INTVL_MS * 1000000) / CLK_NS;
  localparam int U2_IDLE_NS      = 1000;
  localparam int U2_IDLE_CYC     = U2_IDLE_NS / CLK_NS;
  localparam int U3_IDLE_NS      = 10000;
  localparam int U3_IDLE_CYC     = U3_IDLE_NS / CLK_NS;
  localparam logic [3:0]  AUX_CMD_WR   = 4'h8;
  localparam logic [19:0] LANE_ADDR    = 20'h00101;
  localparam logic [19:0] POWER_ADDR   = 20'h00600;
  localparam logic [2:0]  HDR_BYTES    = 3'h3;
  localparam logic [2:0]  DATA_IDX     = 3'h4;
  localparam logic [2:0]  MAX_LANES    = 3'h4;
  localparam logic [2:0]  D3_CODE      = 3'h2;
  localparam logic [2:0]  D3_AUX_CODE  = 3'h5;
  localparam logic [3:0]  EQ_OFF       = 4'h0;
  localparam int N_STRAPS = 7;
  localparam int S_SER    = 0;
  localparam int S_UEQ0   = 1;
  localparam int S_UEQ1   = 2;
  localparam int S_DEQ0   = 3;
  localparam int S_DEQ1   = 4;
  localparam int S_CFG0   = 5;
  localparam int S_CFG1   = 6;

  typedef enum logic [1:0] {LV_0 = 2'h0, LV_R = 2'h1, LV_F = 2'h2, LV_1 = 2'h3} lvl_t;
  typedef enum logic [4:0] {
    US_DISC = 5'h01, US_U0 = 5'h02, US_U1 = 5'h04, US_U2 = 5'h08, US_U3 = 5'h10
  } usb_state_t;
  typedef struct packed {
    logic [1:0] dir;
    logic       flip;
    logic       swap;
    logic [1:0] ctl;
  } path_cfg_t;
  typedef struct packed {
    logic       rx_present;
    logic       elec_idle;
    logic       lfps;
    logic       ss_active;
  } usb_line_t;
  typedef struct packed {
    logic       vld;
    logic       start;
    logic [7:0] data;
  } aux_byte_t;
endpackage

// ### design/aux_write_snoop.sv
// watches source-to-sink aux bytes for native writes to lane and power fields
`timescale 1ns/100ps
module aux_write_snoop
  import redriver_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   enable_i,
  input  wire redriver_pkg::aux_byte_t aux_i,
  output logic                        lane_wr_o,
  output logic                        power_wr_o,
  output logic [7:0]                  data_o
);
  logic [2:0]  idx_reg;
  logic [23:0] hdr_reg;
  logic [2:0]  idx;
  logic        is_wr;

  // the start flag marks the first byte of a frame, whatever came before
  assign idx   = aux_i.start ? 3'h0 : idx_reg;
  assign is_wr = enable_i && aux_i.vld && (idx == DATA_IDX) && (hdr_reg[23:20] == AUX_CMD_WR);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      idx_reg <= 3'h0;
    end else if (aux_i.vld) begin
      idx_reg <= (idx == 3'h7) ? idx : idx + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hdr_reg <= 24'h0;
    end else if (aux_i.vld && idx < HDR_BYTES) begin
      hdr_reg <= {hdr_reg[15:0], aux_i.data};
    end
  end

  // only the first data byte counts; burst writes past it are ignored
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lane_wr_o  <= 1'b0;
      power_wr_o <= 1'b0;
      data_o     <= 8'h0;
    end else begin
      lane_wr_o  <= is_wr && (hdr_reg[19:0] == LANE_ADDR); // RULE_01
      power_wr_o <= is_wr && (hdr_reg[19:0] == POWER_ADDR); // RULE_01
      if (is_wr) begin
        data_o <= aux_i.data;
      end
    end
  end
endmodule

// ### design/redriver_ctrl.sv
// control logic of a four-channel alt-mode linear redriver
// Functional notes
// RULE_01: snoop native aux writes to lane, power fields
// RULE_02: lane enables follow last snooped lane count
// RULE_03: sink power D3 disables every dp lane
// RULE_04: snooping on after reset, off by control
// RULE_05: never more than four dp lanes
// RULE_06: infer usb power state from line conditions
// RULE_07: lfps present forces receive equalization off
// RULE_08: otherwise equalization from pins or registers
// RULE_09: periodic receiver detect, then terminate and redrive
// RULE_10: each strap resolves to 0, R, F, 1
// RULE_11: straps latched at internal reset release
// RULE_12: strap pulls disconnected after hold time
// RULE_13: each path eq from own two straps
// RULE_14: per-channel register eq for both directions
// RULE_15: gain and linearity common to all channels
// RULE_16: path direction and mapping from pins or config
// RULE_17: automatic de-emphasis control during lfps
// RULE_18: serial select at level 0 means pin mode
// RULE_19: usb-only after reset until ctl0 pulse; here USB_EN_O is held on but dp lanes still follow ctl[1]
// RULE_20: register settings override pins in register mode
// RULE_21: snoop off holds lanes until config write
`timescale 1ns/100ps
module redriver_ctrl
  import redriver_pkg::*;
#(
  parameter int RXDET_CYC = RXDET_INTVL_CYC
)
(
  input  wire logic                    MCLK_I,
  input  wire logic                    SRST_I,
  input  wire logic [3*N_STRAPS-1:0]   STRAP_I,
  input  wire redriver_pkg::path_cfg_t PATH_PIN_I,
  input  wire redriver_pkg::path_cfg_t CFG_PATH_I,
  input  wire logic [15:0]             CFG_EQ_I,
  input  wire logic [3:0]              CFG_GAIN_I,
  input  wire logic [2:0]              CFG_LANES_I,
  input  wire logic                    CFG_LANE_WR_I,
  input  wire logic                    SNOOP_OFF_I,
  input  wire redriver_pkg::usb_line_t USB_LINE_I,
  input  wire redriver_pkg::aux_byte_t AUX_I,
  output logic                         STRAP_PULL_EN_O,
  output logic                         REG_MODE_O,
  output logic                         RXDET_REQ_O,
  output logic                         RX_TERM_EN_O,
  output logic                         REDRIVE_EN_O,
  output redriver_pkg::usb_state_t     USB_STATE_O,
  output logic                         LFPS_DEEMPH_O,
  output logic [15:0]                  RX_EQ_O,
  output logic [3:0]                   GAIN_LIN_O,
  output redriver_pkg::path_cfg_t      PATH_O,
  output logic                         USB_EN_O,
  output logic [3:0]                   DP_LANE_EN_O
);
  import redriver_pkg::*;

  function automatic lvl_t lvl_decode(input logic [2:0] th); // RULE_10
    case (th)
      3'h0:    lvl_decode = LV_0;
      3'h1:    lvl_decode = LV_R;
      3'h3:    lvl_decode = LV_F;
      3'h7:    lvl_decode = LV_1;
      default: lvl_decode = LV_F;
    endcase
  endfunction

  function automatic logic [2:0] lane_clamp(input logic [7:0] v); // RULE_05
    lane_clamp = (v > {5'h0, MAX_LANES}) ? MAX_LANES : v[2:0];
  endfunction

  function automatic logic [3:0] lane_mask(input logic [2:0] n);
    lane_mask = (n >= MAX_LANES) ? 4'hf : 4'((5'h1 << n) - 5'h1);
  endfunction

  // pin synchronisers; no reset so the latch at release sees live pins
  logic [3*N_STRAPS-1:0] strap_m, strap_s;
  path_cfg_t             path_m, path_s;
  usb_line_t             line_m, line_s;
  always_ff @(posedge MCLK_I) begin
    strap_m <= STRAP_I;
    strap_s <= strap_m;
    path_m  <= PATH_PIN_I;
    path_s  <= path_m;
    line_m  <= USB_LINE_I;
    line_s  <= line_m;
  end

  // strap latch and pull-resistor release
  lvl_t        strap_reg [N_STRAPS];
  logic        srst_q;
  logic        latched_reg;
  logic [11:0] hold_cnt_reg;
  logic        hold_done;
  logic        release_edge;
  assign release_edge = srst_q && !SRST_I;
  assign hold_done    = hold_cnt_reg == 12'(STRAP_HOLD_CYC);

  always_ff @(posedge MCLK_I) begin
    srst_q <= SRST_I;
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < N_STRAPS; i++) begin
        strap_reg[i] <= LV_F;
      end
    end else if (release_edge) begin
      for (int i = 0; i < N_STRAPS; i++) begin
        strap_reg[i] <= lvl_decode(strap_s[3*i +: 3]); // RULE_11
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      latched_reg     <= 1'b0;
      hold_cnt_reg    <= 12'h0;
      STRAP_PULL_EN_O <= 1'b1;
    end else begin
      if (release_edge) begin
        latched_reg <= 1'b1;
      end
      if (latched_reg && !hold_done) begin
        hold_cnt_reg <= hold_cnt_reg + 12'h1;
      end
      if (hold_done) begin
        STRAP_PULL_EN_O <= 1'b0; // RULE_12
      end
    end
  end

  // pin mode when the serial select strap reads level 0
  logic reg_mode;
  assign reg_mode = strap_reg[S_SER] != LV_0; // RULE_18

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      REG_MODE_O <= 1'b0;
    end else begin
      REG_MODE_O <= reg_mode;
    end
  end

  // path selection and the power-up usb default
  path_cfg_t path_sel;
  logic      ctl0_q;
  logic      usb_dflt_reg;
  assign path_sel = reg_mode ? CFG_PATH_I : path_s; // RULE_16 RULE_20

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      PATH_O       <= '0;
      ctl0_q       <= 1'b0;
      usb_dflt_reg <= 1'b1;
      USB_EN_O     <= 1'b0;
    end else begin
      PATH_O <= path_sel;
      // path flips from config to pins at the strap latch; that edge is no pulse
      ctl0_q <= path_sel.ctl[0] && latched_reg;
      // a fall of ctl0 after a high seen past the strap latch leaves the default usb mode
      if (ctl0_q && !path_sel.ctl[0]) begin
        usb_dflt_reg <= 1'b0; // RULE_19
      end
      USB_EN_O <= usb_dflt_reg || path_sel.ctl[0]; // RULE_19
    end
  end

  // lane count and sink power state, from snooping or configuration
  logic       snoop_en;
  logic       lane_wr, power_wr;
  logic [7:0] snoop_data;
  logic [2:0] lane_cnt_reg;
  logic       power_d3_reg;
  logic [2:0] dp_max;
  logic [2:0] lanes_act;
  assign snoop_en = !SNOOP_OFF_I && path_sel.ctl[1]; // RULE_04

  aux_write_snoop u_snoop (
    .clk_i      (MCLK_I),
    .srst_i     (SRST_I),
    .enable_i   (snoop_en),
    .aux_i      (AUX_I),
    .lane_wr_o  (lane_wr),
    .power_wr_o (power_wr),
    .data_o     (snoop_data)
  );

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      lane_cnt_reg <= MAX_LANES;
      power_d3_reg <= 1'b0;
    end else if (SNOOP_OFF_I) begin
      // without snooping the captured state stands until software writes
      if (CFG_LANE_WR_I) begin
        lane_cnt_reg <= lane_clamp({5'h0, CFG_LANES_I}); // RULE_21
        power_d3_reg <= 1'b0;
      end
    end else begin
      if (lane_wr) begin
        lane_cnt_reg <= lane_clamp({3'h0, snoop_data[4:0]}); // RULE_02
      end
      if (power_wr) begin
        power_d3_reg <= (snoop_data[2:0] == D3_CODE) || (snoop_data[2:0] == D3_AUX_CODE);
      end
    end
  end

  // ctl picks four lanes, two beside usb, or none while ctl[1] is low
  assign dp_max    = path_sel.ctl[1] ? (path_sel.ctl[0] ? 3'h2 : MAX_LANES) : 3'h0;
  assign lanes_act = (lane_cnt_reg < dp_max) ? lane_cnt_reg : dp_max;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      DP_LANE_EN_O <= 4'h0;
    end else begin
      DP_LANE_EN_O <= power_d3_reg ? 4'h0 : lane_mask(lanes_act); // RULE_03 RULE_05
    end
  end

  // usb power state from termination, idle, lfps and signalling only
  usb_state_t  st_reg, st_next;
  logic [11:0] idle_cnt_reg;
  logic [21:0] rxdet_cnt_reg;
  logic        rxdet_fire;
  logic        wake;
  assign rxdet_fire = rxdet_cnt_reg == 22'(RXDET_CYC - 1);
  assign wake       = line_s.lfps || line_s.ss_active;

  always_comb begin
    st_next = st_reg;
    case (st_reg) // RULE_06
      US_DISC: if (line_s.rx_present) st_next = US_U0; // RULE_09
      US_U0:   if (!line_s.rx_present) st_next = US_DISC;
               else if (line_s.elec_idle) st_next = US_U1;
      US_U1:   if (!line_s.rx_present) st_next = US_DISC;
               else if (wake) st_next = US_U0;
               else if (idle_cnt_reg >= 12'(U2_IDLE_CYC)) st_next = US_U2;
      US_U2:   if (!line_s.rx_present) st_next = US_DISC;
               else if (wake) st_next = US_U0;
               else if (idle_cnt_reg >= 12'(U3_IDLE_CYC)) st_next = US_U3;
      US_U3:   if (!line_s.rx_present) st_next = US_DISC;
               else if (line_s.lfps) st_next = US_U0;
      default: st_next = US_DISC;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      st_reg <= US_DISC;
    end else begin
      st_reg <= st_next;
    end
  end

  // idle time counts in any state while that state holds and the line stays quiet
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || st_next != st_reg || wake) begin
      idle_cnt_reg <= 12'h0;
    end else if (idle_cnt_reg != 12'hfff) begin
      idle_cnt_reg <= idle_cnt_reg + 12'h1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I || st_reg != US_DISC || rxdet_fire) begin
      rxdet_cnt_reg <= 22'h0;
    end else begin
      rxdet_cnt_reg <= rxdet_cnt_reg + 22'h1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      RXDET_REQ_O  <= 1'b0;
      RX_TERM_EN_O <= 1'b0;
      REDRIVE_EN_O <= 1'b0;
      USB_STATE_O  <= US_DISC;
    end else begin
      RXDET_REQ_O  <= (st_reg == US_DISC) && rxdet_fire; // RULE_09
      RX_TERM_EN_O <= st_reg != US_DISC; // RULE_09
      REDRIVE_EN_O <= st_reg == US_U0;
      USB_STATE_O  <= st_reg;
    end
  end

  // equalization, gain and lfps handling
  logic [3:0]  ueq_pin, deq_pin, ueq, deq;
  logic [15:0] eq_sel;
  assign ueq_pin = {strap_reg[S_UEQ1], strap_reg[S_UEQ0]}; // RULE_13
  assign deq_pin = {strap_reg[S_DEQ1], strap_reg[S_DEQ0]}; // RULE_13
  // swap exchanges the two facing ports' settings along with direction
  assign ueq     = path_sel.swap ? deq_pin : ueq_pin;
  assign deq     = path_sel.swap ? ueq_pin : deq_pin;
  assign eq_sel  = reg_mode ? CFG_EQ_I : {deq, deq, ueq, ueq}; // RULE_14 RULE_20

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      RX_EQ_O       <= 16'h0;
      LFPS_DEEMPH_O <= 1'b0;
      GAIN_LIN_O    <= 4'h0;
    end else begin
      RX_EQ_O       <= line_s.lfps ? {4{EQ_OFF}} : eq_sel; // RULE_07 RULE_08
      LFPS_DEEMPH_O <= line_s.lfps; // RULE_17
      GAIN_LIN_O    <= reg_mode ? CFG_GAIN_I
                                : {strap_reg[S_CFG1], strap_reg[S_CFG0]}; // RULE_15
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  chk_lfps_eq_off: assert property (line_s.lfps |=> RX_EQ_O == 16'h0) // RULE_07
    else $error("eq not off during lfps");
  chk_eq_pin_mode: assert property (!line_s.lfps && !reg_mode && !path_sel.swap
    |=> RX_EQ_O[3:0] == $past(ueq_pin)) // RULE_08
    else $error("pin eq not applied");
  chk_d3_lanes_off: assert property (power_d3_reg |=> DP_LANE_EN_O == 4'h0) // RULE_03
    else $error("lanes on in D3");
  chk_lane_cnt_max: assert property (lane_cnt_reg <= MAX_LANES) // RULE_05
    else $error("lane count above four");
  chk_snoop_lane: assert property (!SNOOP_OFF_I && lane_wr
    |=> lane_cnt_reg == lane_clamp({3'h0, $past(snoop_data[4:0])})) // RULE_02
    else $error("snooped lane count lost");
  chk_snoop_off_hold: assert property (SNOOP_OFF_I && !CFG_LANE_WR_I
    |=> $stable(lane_cnt_reg) && $stable(power_d3_reg)) // RULE_21
    else $error("lane state moved with snoop off");
  chk_strap_latch: assert property (release_edge
    |=> strap_reg[S_SER] == lvl_decode($past(strap_s[2:0]))) // RULE_11
    else $error("strap not latched at release");
  chk_pull_release: assert property (release_edge
    |-> STRAP_PULL_EN_O [*8] ##0 (hold_cnt_reg < 12'(STRAP_HOLD_CYC))) // RULE_12
    else $error("pulls released early");
  chk_pull_off_done: assert property (hold_done |=> !STRAP_PULL_EN_O) // RULE_12
    else $error("pulls still on after hold");
  chk_term_in_u0: assert property (st_reg == US_U0 |=> RX_TERM_EN_O && REDRIVE_EN_O) // RULE_09
    else $error("u0 without termination");
  chk_usb_default: assert property ($fell(srst_q) |=> USB_EN_O) // RULE_19
    else $error("usb not default after reset");
  chk_deemph_lfps: assert property (line_s.lfps |=> LFPS_DEEMPH_O) // RULE_17
    else $error("de-emphasis not automatic");
  chk_reg_gain: assert property (reg_mode |=> GAIN_LIN_O == $past(CFG_GAIN_I)) // RULE_20
    else $error("register gain not used");

  cov_d3_entry: cover property (power_wr ##1 power_d3_reg);
  cov_u3_wake:  cover property (st_reg == US_U3 ##1 st_reg == US_U0);
  cov_usb_exit: cover property ($fell(usb_dflt_reg));
  cov_rxdet:    cover property (RXDET_REQ_O ##[1:20] st_reg == US_U0);
endmodule

// ### verification/dp_usb_partner.sv
// far-side model: dp source aux byte stream and usb line detector levels
`timescale 1ns/100ps
module dp_usb_partner
(
  input  wire logic               clk_i,
  output redriver_pkg::aux_byte_t aux_o,
  output redriver_pkg::usb_line_t line_o
);
  import redriver_pkg::*;

  initial begin
    aux_o  = '0;
    line_o = '0;
  end

  // an idle byte lane toggles every cycle so a stale byte never looks valid
  task automatic aux_idle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      aux_o <= '{vld: 1'b0, start: 1'b0, data: ~aux_o.data};
    end
  endtask

  // request: command nibble with address, length byte, one data byte
  task automatic aux_frame(input logic [3:0] cmd, input logic [19:0] addr,
                           input logic [7:0] data);
    logic [7:0] b [5];
    b = '{{cmd, addr[19:16]}, addr[15:8], addr[7:0], 8'h00, data};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      aux_o <= '{vld: 1'b1, start: (i == 0), data: b[i]};
    end
  endtask

  // detector levels: rx_present, elec_idle, lfps, ss_active
  task automatic line_set(input logic [3:0] v);
    @(posedge clk_i);
    line_o <= v;
  endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the redriver control logic
`timescale 1ns/100ps
module tb_top;
  import redriver_pkg::*;
  localparam int RXDET_SIM = 50;

  logic                  MCLK_I;
  logic                  SRST_I;
  logic [3*N_STRAPS-1:0] STRAP_I;
  path_cfg_t             PATH_PIN_I, CFG_PATH_I, PATH_O;
  logic [15:0]           CFG_EQ_I, RX_EQ_O;
  logic [3:0]            CFG_GAIN_I, GAIN_LIN_O, DP_LANE_EN_O;
  logic [2:0]            CFG_LANES_I;
  logic                  CFG_LANE_WR_I, SNOOP_OFF_I;
  usb_line_t             USB_LINE_I;
  aux_byte_t             AUX_I;
  usb_state_t            USB_STATE_O;
  logic                  STRAP_PULL_EN_O, REG_MODE_O, RXDET_REQ_O, RX_TERM_EN_O;
  logic                  REDRIVE_EN_O, LFPS_DEEMPH_O, USB_EN_O;
  int                    err_total, n_compared;

  redriver_ctrl #(.RXDET_CYC(RXDET_SIM)) redriver_ctrl_i (
    .MCLK_I          (MCLK_I),
    .SRST_I          (SRST_I),
    .STRAP_I         (STRAP_I),
    .PATH_PIN_I      (PATH_PIN_I),
    .CFG_PATH_I      (CFG_PATH_I),
    .CFG_EQ_I        (CFG_EQ_I),
    .CFG_GAIN_I      (CFG_GAIN_I),
    .CFG_LANES_I     (CFG_LANES_I),
    .CFG_LANE_WR_I   (CFG_LANE_WR_I),
    .SNOOP_OFF_I     (SNOOP_OFF_I),
    .USB_LINE_I      (USB_LINE_I),
    .AUX_I           (AUX_I),
    .STRAP_PULL_EN_O (STRAP_PULL_EN_O),
    .REG_MODE_O      (REG_MODE_O),
    .RXDET_REQ_O     (RXDET_REQ_O),
    .RX_TERM_EN_O    (RX_TERM_EN_O),
    .REDRIVE_EN_O    (REDRIVE_EN_O),
    .USB_STATE_O     (USB_STATE_O),
    .LFPS_DEEMPH_O   (LFPS_DEEMPH_O),
    .RX_EQ_O         (RX_EQ_O),
    .GAIN_LIN_O      (GAIN_LIN_O),
    .PATH_O          (PATH_O),
    .USB_EN_O        (USB_EN_O),
    .DP_LANE_EN_O    (DP_LANE_EN_O)
  );

  dp_usb_partner dp_usb_partner_i (.clk_i(MCLK_I), .aux_o(AUX_I), .line_o(USB_LINE_I));

  initial begin
    MCLK_I = 1'b0;
    forever #2 MCLK_I = ~MCLK_I;
  end

  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // outputs are looked at on the falling edge, clear of the update edge
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK_I);
    @(negedge MCLK_I);
  endtask

  function automatic logic [2:0] th(input lvl_t l);
    case (l)
      LV_0:    return 3'h0;
      LV_R:    return 3'h1;
      LV_F:    return 3'h3;
      default: return 3'h7;
    endcase
  endfunction

  task automatic do_reset(input logic [3*N_STRAPS-1:0] s);
    @(posedge MCLK_I);
    SRST_I  <= 1'b1;
    STRAP_I <= s;
    repeat (3) @(posedge MCLK_I);
    @(negedge MCLK_I);
    cmp(STRAP_PULL_EN_O, 16'h1);
    cmp(USB_STATE_O, US_DISC);
    @(posedge MCLK_I) SRST_I <= 1'b0;
  endtask

  task automatic wait_st(input usb_state_t s, input int lim);
    for (int i = 0; i < lim && USB_STATE_O !== s; i++) cyc(1);
    cmp(USB_STATE_O, s);
  endtask

  task automatic send(input logic [3:0] c, input logic [19:0] a, input logic [7:0] d);
    dp_usb_partner_i.aux_frame(c, a, d);
    dp_usb_partner_i.aux_idle(6);
    cyc(1);
  endtask

  // ser 0, ueq {1,R}, deq {0, invalid code read as F}, cfg {R,1}
  task automatic t_straps();
    do_reset({th(LV_R), th(LV_1), th(LV_0), 3'h5, th(LV_1), th(LV_R), th(LV_0)});
    cyc(4);
    cmp(REG_MODE_O, 16'h0);
    cmp(RX_EQ_O, 16'h22dd);
    cmp(GAIN_LIN_O, 16'h7);
    cmp(USB_EN_O, 16'h1);
    @(posedge MCLK_I) STRAP_I <= '1;
    cyc(2395);
    cmp(RX_EQ_O, 16'h22dd);
    cmp(STRAP_PULL_EN_O, 16'h1);
    cyc(200);
    cmp(STRAP_PULL_EN_O, 16'h0);
  endtask

  task automatic t_rxdet();
    int n;
    n = 0;
    for (int i = 0; i < 210; i++) begin
      cyc(1);
      n += (RXDET_REQ_O === 1'b1);
    end
    cmp(n == 4 || n == 5, 16'h1);
  endtask

  task automatic t_usb();
    dp_usb_partner_i.line_set(4'h8);
    cyc(6);
    cmp(USB_STATE_O, US_U0);
    cmp(RX_TERM_EN_O, 16'h1);
    cmp(REDRIVE_EN_O, 16'h1);
    dp_usb_partner_i.line_set(4'hc);
    cyc(8);
    cmp(USB_STATE_O, US_U1);
    dp_usb_partner_i.line_set(4'h9);
    cyc(6);
    cmp(USB_STATE_O, US_U0);
    dp_usb_partner_i.line_set(4'hc);
    cyc(200);
    cmp(USB_STATE_O, US_U1);
    wait_st(US_U2, 100);
    cyc(2400);
    cmp(USB_STATE_O, US_U2);
    wait_st(US_U3, 200);
    dp_usb_partner_i.line_set(4'ha);
    cyc(6);
    cmp(USB_STATE_O, US_U0);
    cmp(RX_EQ_O, 16'h0);
    cmp(LFPS_DEEMPH_O, 16'h1);
    dp_usb_partner_i.line_set(4'h8);
    cyc(6);
    cmp(RX_EQ_O, 16'h22dd);
    cmp(LFPS_DEEMPH_O, 16'h0);
    dp_usb_partner_i.line_set(4'h0);
    cyc(6);
    cmp(USB_STATE_O, US_DISC);
    cmp(RX_TERM_EN_O, 16'h0);
    cmp(REDRIVE_EN_O, 16'h0);
  endtask

  task automatic t_path();
    @(posedge MCLK_I) PATH_PIN_I <= 6'h1c;
    cyc(5);
    cmp(PATH_O, 16'h1c);
    cmp(RX_EQ_O, 16'hdd22);
    @(posedge MCLK_I) PATH_PIN_I <= 6'h01;
    cyc(5);
    cmp(USB_EN_O, 16'h1);
    @(posedge MCLK_I) PATH_PIN_I <= 6'h00;
    cyc(5);
    cmp(USB_EN_O, 16'h0);
  endtask

  // rows: command, address, data byte, expected lane enables
  task automatic t_aux();
    logic [35:0] tbl [10] = '{36'h800101023, 36'h80010107f, 36'h800101011,
      36'h800102041, 36'h900101041, 36'h800600020, 36'h800101040,
      36'h80060001f, 36'h800600050, 36'h80060001f};
    @(posedge MCLK_I) PATH_PIN_I <= 6'h02;
    cyc(5);
    cmp(DP_LANE_EN_O, 16'hf);
    foreach (tbl[i]) begin
      send(tbl[i][35:32], tbl[i][31:12], tbl[i][11:4]);
      cmp(DP_LANE_EN_O, tbl[i][3:0]);
    end
    dp_usb_partner_i.aux_frame(4'h8, LANE_ADDR, 8'h02);
    send(4'h8, LANE_ADDR, 8'h03);
    cmp(DP_LANE_EN_O, 16'h7);
    @(posedge MCLK_I) PATH_PIN_I <= 6'h03;
    cyc(5);
    cmp(DP_LANE_EN_O, 16'h3);
    @(posedge MCLK_I) PATH_PIN_I <= 6'h02;
    cyc(5);
  endtask

  task automatic t_snoop_off();
    send(4'h8, POWER_ADDR, 8'h02);
    cmp(DP_LANE_EN_O, 16'h0);
    @(posedge MCLK_I) SNOOP_OFF_I <= 1'b1;
    dp_usb_partner_i.aux_frame(4'h8, POWER_ADDR, 8'h01);
    send(4'h8, LANE_ADDR, 8'h01);
    cmp(DP_LANE_EN_O, 16'h0);
    @(posedge MCLK_I);
    CFG_LANES_I   <= 3'h6;
    CFG_LANE_WR_I <= 1'b1;
    @(posedge MCLK_I) CFG_LANE_WR_I <= 1'b0;
    cyc(4);
    cmp(DP_LANE_EN_O, 16'hf);
    @(posedge MCLK_I) SNOOP_OFF_I <= 1'b0;
  endtask

  task automatic t_reg();
    @(posedge MCLK_I);
    CFG_EQ_I   <= 16'h3a5c;
    CFG_GAIN_I <= 4'hb;
    CFG_PATH_I <= 6'h26;
    do_reset({th(LV_0), th(LV_0), th(LV_0), th(LV_0), th(LV_0), th(LV_0), th(LV_F)});
    cyc(4);
    cmp(REG_MODE_O, 16'h1);
    cmp(RX_EQ_O, 16'h3a5c);
    cmp(GAIN_LIN_O, 16'hb);
    cmp(PATH_O, 16'h26);
    dp_usb_partner_i.line_set(4'h2);
    cyc(6);
    cmp(RX_EQ_O, 16'h0);
    dp_usb_partner_i.line_set(4'h0);
    @(posedge MCLK_I) CFG_EQ_I <= 16'h1234;
    cyc(6);
    cmp(RX_EQ_O, 16'h1234);
  endtask

  initial begin
    err_total     = 0;
    n_compared    = 0;
    SRST_I        = 1'b1;
    STRAP_I       = '0;
    PATH_PIN_I    = '0;
    CFG_PATH_I    = '0;
    CFG_EQ_I      = 16'h0;
    CFG_GAIN_I    = 4'h0;
    CFG_LANES_I   = 3'h0;
    CFG_LANE_WR_I = 1'b0;
    SNOOP_OFF_I   = 1'b0;
    t_straps();
    t_rxdet();
    t_usb();
    t_path();
    t_aux();
    t_snoop_off();
    t_reg();
    summarize();
  end

  // the tests need about 5900 cycles; this limit leaves ample margin
  initial begin
    repeat (20000) @(posedge MCLK_I);
    err_total++;
    summarize();
  end
endmodule
